// ===== rtl/serial_mem_pkg.sv
// Shared constants of the two-wire serial memory target: command codes,
// field positions, address width and clock figures.
// Assumes a single 10 MHz system clock that oversamples the bus lines.
package serial_mem_pkg;
	localparam int       CLK_PERIOD_NS = 100;
	localparam int       ADDR_W        = 13;
	localparam int       ADDR_HI_USED  = 5;
	localparam int       REC_W         = 20;
	localparam logic [7:0] RSV_ID      = 8'hF8;
	localparam logic [7:0] SLEEP_CMD   = 8'h86;
	localparam logic [7:0] ID_CMD      = 8'hF9;
	localparam logic [4:0] HS_CODE     = 5'h01;
	localparam int       TYPE_MSB      = 7;
	localparam int       TYPE_LSB      = 4;
	localparam int       SEL_MSB       = 3;
	localparam int       SEL_LSB       = 1;
	localparam int       HS_LSB        = 3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;
	localparam logic [1:0] ID_LAST     = 2'h2;
	localparam logic [1:0] IDX_DATA    = 2'h3;
	localparam logic       SYNC_IDLE   = 1'b1;
endpackage : serial_mem_pkg

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for a group of slow pin levels.
// Assumes the inputs are quasi-static or much slower than CLK.
`timescale 1ns/100ps
module pin_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end
endmodule : pin_sync

// ===== rtl/twowire_mem_target.sv
// Two-wire bus target of a byte-addressed serial memory: random and
// sequential read, write-form addressing, high-speed entry, sleep, ID read.
// Assumes SCL/SDA arrive as open-drain levels from a master and are
// oversampled by CLK; the bench runs SCL at 800 ns period.
// How it works
// - Write-form address word, two address bytes, restart, read word returns addressed byte.
// - Each master acknowledge makes the device send the next sequential byte.
// - Read pointer wraps from the last location to address zero.
// - Device never acknowledges the high-speed entry code.
// - Once entered, the device only raises HS_MODE; transfers still run at rates CLK can oversample.
// - A stop ends high-speed mode for both parties.
// - Sleep: start F8 ack, address word ack, restart plus 86.
// - Device acknowledges 86, then sleeps with regulator stopped.
// - Bus lines keep being watched while asleep.
// - Wake: matching address word; recovery starts at ninth rising clock.
// - Standby only after recovery time; commands then begin with start.
// - Fixed read-only three-byte identifier: maker code then product code.
// - ID read: start F8, acked address word, restart F9, three bytes out.
// - Acknowledge after third ID byte restarts output from the first.
// - Address word answered only when its select bits equal the pins.
// - Stop before an acknowledge completes abandons the operation.
`timescale 1ns/100ps
module twowire_mem_target #(
	parameter logic [3:0]  DEV_TYPE = 4'h5,       // Arbitrary value
	parameter logic [23:0] ID_CODE  = 24'h3C5A96, // Arbitrary value
	parameter int          REC_NS   = 100000
) (
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	output logic      SDA_O,
	output logic      SDA_OE,
	input  wire logic SELECT_PIN_HIGH,
	input  wire logic SELECT_PIN_MID,
	input  wire logic SELECT_PIN_LOW,
	output logic      SLEEP,
	output logic      RECOVERING,
	output logic      HS_MODE
);
	localparam int REC_RAW = (REC_NS + serial_mem_pkg::CLK_PERIOD_NS - 1) / serial_mem_pkg::CLK_PERIOD_NS;
	localparam int REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;
	localparam int AW      = serial_mem_pkg::ADDR_W;
	localparam int RW      = serial_mem_pkg::REC_W;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAKE9, ST_IGNORE} state_t;
	typedef enum logic [1:0] {MD_NONE, MD_WRITE, MD_RSV, MD_RSV_OK} mode_t;

	logic [7:0] mem [0:(1 << AW) - 1];

	logic [1:0]    bus_s;
	logic [2:0]    sel_s;
	logic          scl_s, sda_s, scl_d_r, sda_d_r;
	logic          start, stop, scl_rise, scl_fall, dev_hit;
	state_t        state_r, state_nxt;
	mode_t         mode_r, mode_nxt;
	logic [3:0]    bit_cnt_r, bit_cnt_nxt;
	logic [1:0]    byte_idx_r, byte_idx_nxt;
	logic [7:0]    sh_r, sh_nxt, tx_byte;
	logic [AW-1:0] ptr_r, ptr_nxt;
	logic          rd_r, rd_nxt;
	logic          id_mode_r, id_mode_nxt;
	logic [1:0]    id_idx_r, id_idx_nxt;
	logic          ack_seen_r, ack_seen_nxt;
	logic          sleep_r, sleep_nxt;
	logic          sleep_pend_r, sleep_pend_nxt;
	logic          hs_r, hs_nxt;
	logic [RW-1:0] rec_cnt_r, rec_cnt_nxt;
	logic          sda_oe_r, sda_oe_nxt;
	logic          tx_load, mem_we;

	// Bus lines idle high, so the synchroniser resets high to avoid a false start
	pin_sync #(.W(2), .RST_VAL({2{serial_mem_pkg::SYNC_IDLE}})) u_bus_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     ({SCL_I, SDA_I}),
		.q     (bus_s)
	);
	pin_sync #(.W(3), .RST_VAL(3'h0)) u_sel_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     ({SELECT_PIN_HIGH, SELECT_PIN_MID, SELECT_PIN_LOW}),
		.q     (sel_s)
	);

	// Lines are watched in every state, asleep or not
	always_comb begin
		scl_s    = bus_s[1];
		sda_s    = bus_s[0];
		start    = scl_s && scl_d_r && sda_d_r && !sda_s;
		stop     = scl_s && scl_d_r && !sda_d_r && sda_s;
		scl_rise = scl_s && !scl_d_r;
		scl_fall = !scl_s && scl_d_r;
		// Select bits arrive highest first, matching the pin order
		dev_hit  = (sh_r[serial_mem_pkg::TYPE_MSB:serial_mem_pkg::TYPE_LSB] == DEV_TYPE)
			&& (sh_r[serial_mem_pkg::SEL_MSB:serial_mem_pkg::SEL_LSB] == sel_s);
		case (id_idx_r)
			2'h0:    tx_byte = ID_CODE[23:16];
			2'h1:    tx_byte = ID_CODE[15:8];
			default: tx_byte = ID_CODE[7:0];
		endcase
		if (!id_mode_r) begin
			tx_byte = mem[ptr_r];
		end
	end

	always_comb begin
		state_nxt      = state_r;
		mode_nxt       = mode_r;
		bit_cnt_nxt    = bit_cnt_r;
		byte_idx_nxt   = byte_idx_r;
		sh_nxt         = sh_r;
		ptr_nxt        = ptr_r;
		rd_nxt         = rd_r;
		id_mode_nxt    = id_mode_r;
		id_idx_nxt     = id_idx_r;
		ack_seen_nxt   = ack_seen_r;
		sleep_nxt      = sleep_r;
		sleep_pend_nxt = sleep_pend_r;
		hs_nxt         = hs_r;
		rec_cnt_nxt    = rec_cnt_r;
		tx_load        = 1'b0;
		mem_we         = 1'b0;
		if (rec_cnt_r != '0) begin
			rec_cnt_nxt = rec_cnt_r - 1'b1;
			if (rec_cnt_r == RW'(1)) begin
				sleep_nxt = 1'b0;
			end
		end
		if (stop) begin
			// Abandons any unfinished byte and leaves high-speed
			state_nxt      = ST_IDLE;
			mode_nxt       = MD_NONE;
			hs_nxt         = 1'b0;
			sleep_pend_nxt = 1'b0;
			id_mode_nxt    = 1'b0;
		end else if (start && rec_cnt_r == '0) begin
			// Commands wait until recovery is over
			state_nxt    = ST_RX;
			bit_cnt_nxt  = 4'h0;
			byte_idx_nxt = 2'h0;
			id_mode_nxt  = 1'b0;
			if (mode_r != MD_RSV_OK) begin
				mode_nxt = MD_NONE;
			end
		end else begin
			case (state_r)
				ST_RX: begin
					if (scl_rise && bit_cnt_r != serial_mem_pkg::BITS_PER_BYTE) begin
						sh_nxt      = {sh_r[6:0], sda_s};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == serial_mem_pkg::BITS_PER_BYTE) begin
						state_nxt    = ST_IGNORE;
						bit_cnt_nxt  = 4'h0;
						rd_nxt       = 1'b0;
						byte_idx_nxt = (byte_idx_r == serial_mem_pkg::IDX_DATA) ? byte_idx_r : byte_idx_r + 2'h1;
						if (byte_idx_r == 2'h0) begin
							mode_nxt = MD_NONE;
							if (sleep_r) begin
								if (dev_hit) begin
									state_nxt = ST_WAKE9;
								end
							end else if (sh_r[7:serial_mem_pkg::HS_LSB] == serial_mem_pkg::HS_CODE) begin
								// Left released so the master sees a not-acknowledge
								hs_nxt = 1'b1;
							end else if (sh_r == serial_mem_pkg::RSV_ID) begin
								mode_nxt  = MD_RSV;
								state_nxt = ST_ACK;
							end else if (mode_r == MD_RSV_OK && sh_r == serial_mem_pkg::SLEEP_CMD) begin
								state_nxt      = ST_ACK;
								sleep_pend_nxt = 1'b1;
							end else if (mode_r == MD_RSV_OK && sh_r == serial_mem_pkg::ID_CMD) begin
								state_nxt   = ST_ACK;
								rd_nxt      = 1'b1;
								id_mode_nxt = 1'b1;
								id_idx_nxt  = 2'h0;
							end else if (dev_hit) begin
								state_nxt = ST_ACK;
								rd_nxt    = sh_r[0];
								mode_nxt  = sh_r[0] ? MD_NONE : MD_WRITE;
							end
						end else if (mode_r == MD_RSV) begin
							if (dev_hit) begin
								state_nxt = ST_ACK;
								mode_nxt  = MD_RSV_OK;
							end
						end else if (mode_r == MD_WRITE) begin
							state_nxt = ST_ACK;
							// Top three high-address bits are dropped
							if (byte_idx_r == 2'h1) begin
								ptr_nxt = {sh_r[serial_mem_pkg::ADDR_HI_USED-1:0], ptr_r[7:0]};
							end else if (byte_idx_r == 2'h2) begin
								ptr_nxt = {ptr_r[AW-1:8], sh_r};
							end else begin
								mem_we  = 1'b1;
								ptr_nxt = ptr_r + 1'b1;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (sleep_pend_r) begin
							sleep_nxt      = 1'b1;
							sleep_pend_nxt = 1'b0;
							mode_nxt       = MD_NONE;
							state_nxt      = ST_IDLE;
						end else if (rd_r) begin
							tx_load = 1'b1;
						end else begin
							state_nxt = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_r == serial_mem_pkg::TX_LAST_BIT) begin
							state_nxt = ST_TXACK;
						end else begin
							sh_nxt      = {sh_r[6:0], 1'b0};
							bit_cnt_nxt = bit_cnt_r + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						ack_seen_nxt = !sda_s;
					end else if (scl_fall) begin
						if (ack_seen_r) begin
							tx_load = 1'b1;
						end else begin
							state_nxt = ST_IGNORE;
						end
					end
				end
				ST_WAKE9: begin
					if (scl_rise) begin
						rec_cnt_nxt = RW'(REC_CYC);
						state_nxt   = ST_IGNORE;
					end
				end
				default: begin
					state_nxt = state_r;
				end
			endcase
		end
		if (tx_load) begin
			state_nxt   = ST_TX;
			sh_nxt      = tx_byte;
			bit_cnt_nxt = 4'h0;
			if (id_mode_r) begin
				id_idx_nxt = (id_idx_r == serial_mem_pkg::ID_LAST) ? 2'h0 : id_idx_r + 2'h1;
			end else begin
				ptr_nxt = ptr_r + 1'b1;
			end
		end
		// Open-drain: only acknowledge and low data bits pull the line
		sda_oe_nxt = (state_nxt == ST_ACK) || (state_nxt == ST_TX && !sh_nxt[7]);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_d_r      <= 1'b1;
			sda_d_r      <= 1'b1;
			state_r      <= ST_IDLE;
			mode_r       <= MD_NONE;
			bit_cnt_r    <= 4'h0;
			byte_idx_r   <= 2'h0;
			sh_r         <= 8'h00;
			ptr_r        <= '0;
			rd_r         <= 1'b0;
			id_mode_r    <= 1'b0;
			id_idx_r     <= 2'h0;
			ack_seen_r   <= 1'b0;
			sleep_r      <= 1'b0;
			sleep_pend_r <= 1'b0;
			hs_r         <= 1'b0;
			rec_cnt_r    <= '0;
			sda_oe_r     <= 1'b0;
		end else begin
			scl_d_r      <= scl_s;
			sda_d_r      <= sda_s;
			state_r      <= state_nxt;
			mode_r       <= mode_nxt;
			bit_cnt_r    <= bit_cnt_nxt;
			byte_idx_r   <= byte_idx_nxt;
			sh_r         <= sh_nxt;
			ptr_r        <= ptr_nxt;
			rd_r         <= rd_nxt;
			id_mode_r    <= id_mode_nxt;
			id_idx_r     <= id_idx_nxt;
			ack_seen_r   <= ack_seen_nxt;
			sleep_r      <= sleep_nxt;
			sleep_pend_r <= sleep_pend_nxt;
			hs_r         <= hs_nxt;
			rec_cnt_r    <= rec_cnt_nxt;
			sda_oe_r     <= sda_oe_nxt;
		end
	end

	// Array has no reset, so contents are undefined until written
	always_ff @(posedge CLK) begin
		if (mem_we) begin
			mem[ptr_r] <= sh_r;
		end
	end

	// High-speed only sets a flag: real 3.4 MHz clocking needs a faster CLK
	assign SDA_O      = 1'b0;
	assign SDA_OE     = sda_oe_r;
	assign SLEEP      = sleep_r;
	assign RECOVERING = (rec_cnt_r != '0);
	assign HS_MODE    = hs_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_byte_done;
		state_r == ST_RX && scl_fall && !start && !stop && bit_cnt_r == serial_mem_pkg::BITS_PER_BYTE;
	endsequence
	sequence s_first_byte;
		s_byte_done ##0 (byte_idx_r == 2'h0 && !sleep_r);
	endsequence
	sequence s_ack_end;
		state_r == ST_ACK && scl_fall && !stop && !start;
	endsequence

	a_hs_never_acked: assert property (
		(s_first_byte ##0 sh_r[7:serial_mem_pkg::HS_LSB] == serial_mem_pkg::HS_CODE) |=> !SDA_OE && HS_MODE)
		else $error("high-speed code was acknowledged");
	a_select_match_ack: assert property (
		(s_first_byte ##0 (sh_r[7:1] == {DEV_TYPE, sel_s})) |=> SDA_OE && state_r == ST_ACK)
		else $error("matching address word not acknowledged");
	a_stop_abandons: assert property (
		stop |=> state_r == ST_IDLE && !SDA_OE ##1 !SDA_OE)
		else $error("stop did not release the bus");
	a_stop_ends_hs: assert property (
		stop |=> !HS_MODE)
		else $error("high-speed survived a stop");
	a_ptr_wraps: assert property (
		(tx_load && !id_mode_r && ptr_r == '1 && !stop && !start) |=> ptr_r == '0)
		else $error("pointer did not wrap to zero");
	a_id_restart: assert property (
		(tx_load && id_mode_r && id_idx_r == serial_mem_pkg::ID_LAST) |=> id_idx_r == 2'h0 && sh_r == ID_CODE[7:0])
		else $error("ID read did not restart at first byte");
	a_sleep_after_ack: assert property (
		(s_ack_end ##0 sleep_pend_r) |=> SLEEP && !SDA_OE && state_r == ST_IDLE)
		else $error("sleep not entered after acknowledge");
	a_recovery_start: assert property (
		(state_r == ST_WAKE9 && scl_rise && !stop && !start) |=> RECOVERING && SLEEP && rec_cnt_r == RW'(REC_CYC))
		else $error("recovery did not start on ninth rising edge");
	a_standby_after_rec: assert property (
		(rec_cnt_r == RW'(1)) |=> !SLEEP && !RECOVERING)
		else $error("standby not reached after recovery");
	a_release_idle: assert property (
		(state_r inside {ST_IDLE, ST_RX, ST_TXACK, ST_WAKE9, ST_IGNORE}) |-> !SDA_OE)
		else $error("data line driven outside ack or read data");
endmodule : twowire_mem_target

// ===== sim/bus_master.sv
// Behavioural two-wire bus controller that drives the serial clock and data.
// Assumes sda is the resolved open-drain level with a pull-up; 800 ns bit period.
`timescale 1ns/100ps
module bus_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// Data moves only in the low phase; sampled in mid high phase
	task automatic bit_x(input logic b, output logic r);
		step(1);
		sda_low = ~b;
		step(3);
		scl = 1'b1;
		step(2);
		r = sda;
		step(2);
		scl = 1'b0;
	endtask : bit_x
	// Also serves as repeated start, after an acknowledge or a not-acknowledge
	task automatic start;
		step(1);
		sda_low = 1'b0;
		step(3);
		scl = 1'b1;
		step(2);
		sda_low = 1'b1;
		step(2);
		scl = 1'b0;
	endtask : start
	// Clock then stands high until the next frame
	task automatic stop;
		step(1);
		sda_low = 1'b1;
		step(3);
		scl = 1'b1;
		step(2);
		sda_low = 1'b0;
		step(6);
	endtask : stop
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask : put
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(~ack, r);
	endtask : get
endmodule : bus_master

// ===== sim/tb_top.sv
// Self-checking bench for the serial memory target: reads, wrap, high-speed, ID, sleep.
// Assumes bus_master drives the bus; recovery shortened to 20 cycles.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	localparam logic [3:0]  DEV = 4'h9;       // Arbitrary value
	localparam logic [23:0] IDV = 24'hA1B2C3; // Arbitrary value
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] sel;
	logic       scl;
	logic       sda_low;
	logic       sda_oe;
	logic       sda_o;
	logic       sleep;
	logic       recovering;
	logic       hs_mode;
	logic [7:0] mem [0:8191];
	int         seed = 54156;
	int         mismatches = 0;
	int         n_tests = 0;
	wire        sda = ~(sda_low | sda_oe);
	always #50 clk = ~clk;
	bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	twowire_mem_target #(.DEV_TYPE(DEV), .ID_CODE(IDV), .REC_NS(2000)) DUT (
		.CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.SELECT_PIN_HIGH(sel[2]), .SELECT_PIN_MID(sel[1]), .SELECT_PIN_LOW(sel[0]),
		.SLEEP(sleep), .RECOVERING(recovering), .HS_MODE(hs_mode));
	function automatic logic [7:0] aw(input logic rw);
		return {DEV, sel, rw};
	endfunction : aw
	function automatic logic [12:0] nx(input logic [12:0] a);
		return a + 13'h0001;
	endfunction : nx
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic addr_phase(input logic [12:0] a, input logic hs);
		logic ack;
		if (hs) begin
			m.start();
			m.put({5'h01, 3'($random(seed))}, ack);
			`CHK("hs code ack", 1'b0, ack)
		end
		m.start();
		if (hs)
			`CHK("hs flag", 1'b1, hs_mode)
		m.put(aw(1'b0), ack);
		`CHK("addr word ack", 1'b1, ack)
		m.put({3'h0, a[12:8]}, ack);
		`CHK("addr hi ack", 1'b1, ack)
		m.put(a[7:0], ack);
		`CHK("addr lo ack", 1'b1, ack)
	endtask : addr_phase
	task automatic wr(input logic [12:0] a, input int n, input logic hs);
		logic       ack;
		logic [7:0] d;
		addr_phase(a, hs);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			m.put(d, ack);
			`CHK("write ack", 1'b1, ack)
			mem[a] = d;
			a = nx(a);
		end
		m.stop();
		`CHK("hs off", 1'b0, hs_mode)
	endtask : wr
	task automatic rd(input logic [12:0] a, input int n, input logic hs);
		logic       ack;
		logic [7:0] d;
		addr_phase(a, hs);
		m.start();
		m.put(aw(1'b1), ack);
		`CHK("read word ack", 1'b1, ack)
		for (int i = 0; i < n; i++) begin
			m.get(i < n - 1, d);
			`CHK("read data", mem[a], d)
			a = nx(a);
		end
		m.stop();
		`CHK("hs off", 1'b0, hs_mode)
	endtask : rd
	task automatic reserved(input logic [7:0] cmd);
		logic ack;
		m.start();
		m.put(serial_mem_pkg::RSV_ID, ack);
		`CHK("reserved ack", 1'b1, ack)
		m.put(aw(1'($random(seed))), ack);
		`CHK("reserved addr ack", 1'b1, ack)
		m.start();
		m.put(cmd, ack);
		`CHK("command ack", 1'b1, ack)
	endtask : reserved
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		close_out();
	end
	initial begin
		logic        ack;
		logic        saw;
		logic [7:0]  d;
		logic [12:0] a;
		logic        r;
		sel = 3'($random(seed));
		repeat (10) @(posedge clk);
		`CHK("reset outputs", 5'h00, {sda_o, sda_oe, sleep, recovering, hs_mode})
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		m.start();
		m.put({DEV, sel ^ 3'h1, 1'b0}, ack);
		`CHK("foreign select ack", 1'b0, ack)
		m.stop();
		m.start();
		for (int i = 7; i > 3; i--) m.bit_x(1'(aw(1'b0) >> i), r);
		m.stop();
		`CHK("abandoned oe", 1'b0, sda_oe)
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 13'h1FFE : 13'($random(seed));
			wr(a, 3, k[0]);
			rd(a, 3, k[1]);
		end
		reserved(serial_mem_pkg::ID_CMD);
		for (int i = 0; i < 4; i++) begin
			m.get(i < 3, d);
			`CHK("id byte", IDV[23 - 8 * (i % 3) -: 8], d)
		end
		m.stop();
		reserved(serial_mem_pkg::SLEEP_CMD);
		m.stop();
		`CHK("asleep", 1'b1, sleep)
		m.start();
		m.put(aw(1'($random(seed))), ack);
		`CHK("wake word ack", 1'b0, ack)
		saw = recovering;
		for (int t = 0; t < 200 && sleep; t++) begin
			@(posedge clk);
			#1;
			saw |= recovering;
		end
		`CHK("recovery seen", 1'b1, saw)
		if (sleep) begin
			mismatches++;
			close_out();
		end
		m.stop();
		rd(a, 1, 1'b0);
		close_out();
	end
endmodule : tb_top
